/* File: ciesu_pkg.sv */
package ciesu_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_PSW = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_SP = 8'h08;
  localparam logic [7:0] OFS_IP = 8'h0C;
  localparam logic [7:0] OFS_CSP = 8'h10;
  localparam logic [7:0] OFS_CP = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_OPER = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;
  // status word, config and command fields
  localparam int LVL_HI = 15;
  localparam int LVL_LO = 12;
  localparam int GIE_BIT = 11;
  localparam int BANK_HI = 9;
  localparam int BANK_LO = 8;
  localparam int SGT_BIT = 0;
  localparam int CMD_RETURN = 0;
  localparam int CMD_TRAP = 1;
  localparam int CMD_SWCTX = 2;
  localparam logic [15:0] PSW_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [3:0] LVL_MAX = 4'hF;
  localparam logic [1:0] BANK_GLOBAL = 2'h0;
  localparam logic [15:0] STK_STEP = 16'h0002;
  localparam logic [7:0] SW_TRAP_CSP = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PUSH_PSW, ST_PUSH_CSP, ST_PUSH_IP, ST_ENTER,
    ST_POP_IP, ST_POP_CSP, ST_POP_PSW, ST_SWCTX
  } ciesu_state_type;
  typedef enum logic [1:0] {K_IRQ, K_HWTRAP, K_SWTRAP} ciesu_kind_type;
endpackage : ciesu_pkg

/* File: ciesu_top.sv */
// Decided for this implementation: the register addresses and register access over APB.
module ciesu_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ciesu_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [ciesu_pkg::DATA_W-1:0] i_pwdata,
  output logic [ciesu_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_irq_req,
  input wire logic i_irq_pet,
  input wire logic [3:0] i_irq_level,
  input wire logic [1:0] i_irq_bank,
  input wire logic [15:0] i_irq_vec_ip,
  input wire logic [7:0] i_irq_vec_csp,
  output logic o_irq_ack,
  input wire logic i_trap_req,
  input wire logic [15:0] i_trap_vec_ip,
  input wire logic [7:0] i_trap_vec_csp,
  output logic o_trap_ack,
  output logic o_stk_we,
  output logic o_stk_re,
  output logic [15:0] o_stk_addr,
  output logic [15:0] o_stk_wdata,
  input wire logic [15:0] i_stk_rdata,
  output logic [15:0] o_psw,
  output logic [15:0] o_ip,
  output logic [7:0] o_csp,
  output logic [15:0] o_cp
);
  import ciesu_pkg::*;

  typedef struct packed {
    ciesu_state_type state;
    ciesu_kind_type kind;
    logic phase;
    logic [15:0] processor_status_word;
    logic sgt_dis;
    logic [15:0] sp;
    logic [15:0] ip;
    logic [7:0] code_segment_pointer;
    logic [15:0] cp;
    logic [15:0] oper;
    logic [3:0] p_lvl;
    logic [1:0] p_bank;
    logic [15:0] p_ip;
    logic [7:0] p_csp;
    logic irq_ack;
    logic trap_ack;
    logic stk_we;
    logic stk_re;
    logic [15:0] stk_addr;
    logic [15:0] stk_wdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ciesu_regs_type;

  ciesu_regs_type s_reg;
  ciesu_regs_type s_next;

  logic [3:0] cur_lvl;
  logic gie_on;
  logic seg_on;
  logic irq_ok;
  logic apb_done;
  logic apb_wr;
  logic [15:0] sp_dn;
  logic [15:0] sp_up;
  logic [31:0] rd_val;
  logic rd_hit;

  // elaboration guards: the logic below hard-codes the status word layout
  // and a one-word-per-register map, so a package edit must keep both whole
  if (LVL_HI - LVL_LO != 3) begin : g_chk_level_width
    $error("priority level field must be four bits wide");
  end
  if (BANK_HI - BANK_LO != 1) begin : g_chk_bank_width
    $error("register bank field must be two bits wide");
  end
  if (LVL_HI > 15 || BANK_LO < 8) begin : g_chk_upper_byte
    $error("interrupt control fields must sit in the upper byte");
  end
  if (GIE_BIT >= LVL_LO || GIE_BIT <= BANK_HI) begin : g_chk_enable_pos
    $error("global enable must sit between level and bank fields");
  end
  if (DATA_W != 32) begin : g_chk_data_width
    $error("register bus must be one 32-bit word");
  end
  if (ADDR_W != 8) begin : g_chk_addr_width
    $error("address bus must match the 8-bit register offsets");
  end
  if (SGT_BIT >= DATA_W) begin : g_chk_cfg_bit
    $error("segmentation bit outside the data word");
  end
  if (CMD_RETURN >= DATA_W || CMD_TRAP >= DATA_W || CMD_SWCTX >= DATA_W) begin : g_chk_cmd_pos
    $error("command bit outside the data word");
  end
  if (CMD_RETURN == CMD_TRAP || CMD_TRAP == CMD_SWCTX || CMD_RETURN == CMD_SWCTX) begin : g_chk_cmd_unique
    $error("command bits must be distinct");
  end
  if (PSW_RST != 16'h0000) begin : g_chk_status_reset
    $error("status word must reset to zero");
  end
  if (SP_RST[0] != 1'b0) begin : g_chk_stack_reset
    $error("stack pointer must reset word aligned");
  end
  if (LVL_MAX != 4'hF) begin : g_chk_trap_level
    $error("trap level must be the highest level");
  end
  if (BANK_GLOBAL != 2'h0) begin : g_chk_global_bank
    $error("global bank code must be zero");
  end
  if (STK_STEP != 16'h0002) begin : g_chk_stack_step
    $error("stack moves by one 16-bit word");
  end

  // every register is one aligned word; the decode compares whole bytes
  if (OFS_PSW[1:0] != 2'h0) begin : g_chk_ofs_status
    $error("status offset not word aligned");
  end
  if (OFS_CFG[1:0] != 2'h0) begin : g_chk_ofs_config
    $error("config offset not word aligned");
  end
  if (OFS_SP[1:0] != 2'h0) begin : g_chk_ofs_stack
    $error("stack pointer offset not word aligned");
  end
  if (OFS_IP[1:0] != 2'h0) begin : g_chk_ofs_instr
    $error("instruction pointer offset not word aligned");
  end
  if (OFS_CSP[1:0] != 2'h0) begin : g_chk_ofs_segment
    $error("segment pointer offset not word aligned");
  end
  if (OFS_CP[1:0] != 2'h0) begin : g_chk_ofs_context
    $error("context pointer offset not word aligned");
  end
  if (OFS_CMD[1:0] != 2'h0) begin : g_chk_ofs_command
    $error("command offset not word aligned");
  end
  if (OFS_OPER[1:0] != 2'h0) begin : g_chk_ofs_operand
    $error("operand offset not word aligned");
  end
  if (OFS_STAT[1:0] != 2'h0) begin : g_chk_ofs_busy
    $error("busy flag offset not word aligned");
  end

  assign cur_lvl = s_reg.processor_status_word[LVL_HI:LVL_LO];
  assign gie_on = s_reg.processor_status_word[GIE_BIT];
  assign seg_on = ~s_reg.sgt_dis;
  // sources already gate their own enables; only global gate and level here
  assign irq_ok = i_irq_req & gie_on & (i_irq_level > cur_lvl);
  assign apb_done = i_psel & i_penable & s_reg.pready;
  assign apb_wr = apb_done & i_pwrite;
  assign sp_dn = s_reg.sp - STK_STEP;
  assign sp_up = s_reg.sp + STK_STEP;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (i_paddr)
      OFS_PSW: rd_val = {16'h0000, s_reg.processor_status_word};
      OFS_CFG: rd_val = {31'h0000_0000, s_reg.sgt_dis};
      OFS_SP: rd_val = {16'h0000, s_reg.sp};
      OFS_IP: rd_val = {16'h0000, s_reg.ip};
      OFS_CSP: rd_val = {24'h00_0000, s_reg.code_segment_pointer};
      OFS_CP: rd_val = {16'h0000, s_reg.cp};
      OFS_CMD: rd_val = 32'h0000_0000;
      OFS_OPER: rd_val = {16'h0000, s_reg.oper};
      OFS_STAT: rd_val = {31'h0000_0000, s_reg.state != ST_IDLE};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.irq_ack = 1'b0;
    s_next.trap_ack = 1'b0;
    s_next.stk_we = 1'b0;
    s_next.stk_re = 1'b0;

    // apb: one wait cycle, then the completing edge commits writes
    s_next.pready = 1'b0;
    if (i_psel & i_penable & ~s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.prdata = rd_val;
      s_next.pslverr = ~rd_hit;
    end
    // a same-edge engine step below overrides this write
    if (apb_wr & rd_hit) begin
      case (i_paddr)
        OFS_PSW: s_next.processor_status_word = i_pwdata[15:0];
        OFS_CFG: s_next.sgt_dis = i_pwdata[SGT_BIT];
        OFS_SP: s_next.sp = i_pwdata[15:0];
        OFS_IP: s_next.ip = i_pwdata[15:0];
        OFS_CSP: s_next.code_segment_pointer = i_pwdata[7:0];
        OFS_CP: s_next.cp = i_pwdata[15:0];
        OFS_OPER: s_next.oper = i_pwdata[15:0];
        default: s_next.oper = s_next.oper;
      endcase
    end

    case (s_reg.state)
      ST_IDLE: begin
        s_next.phase = 1'b0;
        if (i_trap_req) begin
          // traps bypass the enable and the level compare
          s_next.kind = K_HWTRAP;
          s_next.p_lvl = LVL_MAX;
          s_next.p_bank = BANK_GLOBAL;
          s_next.p_ip = i_trap_vec_ip;
          s_next.p_csp = i_trap_vec_csp;
          s_next.state = ST_PUSH_PSW;
        end else if (irq_ok & i_irq_pet) begin
          // event transfer only steals cycles: no stack, no level change
          s_next.irq_ack = 1'b1;
        end else if (irq_ok) begin
          s_next.kind = K_IRQ;
          s_next.p_lvl = i_irq_level;
          s_next.p_bank = i_irq_bank;
          s_next.p_ip = i_irq_vec_ip;
          s_next.p_csp = i_irq_vec_csp;
          s_next.state = ST_PUSH_PSW;
        end else if (apb_wr && i_paddr == OFS_CMD) begin
          if (i_pwdata[CMD_RETURN]) begin
            s_next.state = ST_POP_IP;
          end else if (i_pwdata[CMD_TRAP]) begin
            s_next.kind = K_SWTRAP;
            s_next.p_lvl = cur_lvl;
            s_next.p_bank = s_reg.processor_status_word[BANK_HI:BANK_LO];
            s_next.p_ip = s_reg.oper;
            s_next.p_csp = SW_TRAP_CSP;
            s_next.state = ST_PUSH_PSW;
          end else if (i_pwdata[CMD_SWCTX]) begin
            s_next.state = ST_SWCTX;
          end
        end
      end
      // from here on the request is committed even if enable drops
      ST_PUSH_PSW: begin
        s_next.sp = sp_dn;
        s_next.stk_we = 1'b1;
        s_next.stk_addr = sp_dn;
        s_next.stk_wdata = s_reg.processor_status_word;
        s_next.state = seg_on ? ST_PUSH_CSP : ST_PUSH_IP;
      end
      ST_PUSH_CSP: begin
        s_next.sp = sp_dn;
        s_next.stk_we = 1'b1;
        s_next.stk_addr = sp_dn;
        s_next.stk_wdata = {8'h00, s_reg.code_segment_pointer};
        s_next.state = ST_PUSH_IP;
      end
      ST_PUSH_IP: begin
        s_next.sp = sp_dn;
        s_next.stk_we = 1'b1;
        s_next.stk_addr = sp_dn;
        s_next.stk_wdata = s_reg.ip;
        s_next.state = ST_ENTER;
      end
      ST_ENTER: begin
        // data page and context pointers stay put; local banks are never cleared
        s_next.processor_status_word[LVL_HI:LVL_LO] = s_reg.p_lvl;
        s_next.processor_status_word[BANK_HI:BANK_LO] = s_reg.p_bank;
        s_next.ip = s_reg.p_ip;
        s_next.code_segment_pointer = s_reg.p_csp;
        s_next.irq_ack = s_reg.kind == K_IRQ;
        s_next.trap_ack = s_reg.kind == K_HWTRAP;
        s_next.state = ST_IDLE;
      end
      // each pop takes two edges: strobe the read, then capture the word
      ST_POP_IP: begin
        s_next.phase = ~s_reg.phase;
        if (~s_reg.phase) begin
          s_next.stk_re = 1'b1;
          s_next.stk_addr = s_reg.sp;
        end else begin
          s_next.ip = i_stk_rdata;
          s_next.sp = sp_up;
          s_next.state = seg_on ? ST_POP_CSP : ST_POP_PSW;
        end
      end
      ST_POP_CSP: begin
        s_next.phase = ~s_reg.phase;
        if (~s_reg.phase) begin
          s_next.stk_re = 1'b1;
          s_next.stk_addr = s_reg.sp;
        end else begin
          s_next.code_segment_pointer = i_stk_rdata[7:0];
          s_next.sp = sp_up;
          s_next.state = ST_POP_PSW;
        end
      end
      ST_POP_PSW: begin
        s_next.phase = ~s_reg.phase;
        if (~s_reg.phase) begin
          s_next.stk_re = 1'b1;
          s_next.stk_addr = s_reg.sp;
        end else begin
          // whole word in one edge, so arbitration never sees a mix
          s_next.processor_status_word = i_stk_rdata;
          s_next.sp = sp_up;
          s_next.state = ST_IDLE;
        end
      end
      // old context pointer goes just below the current stack top
      ST_SWCTX: begin
        s_next.sp = sp_dn;
        s_next.stk_we = 1'b1;
        s_next.stk_addr = sp_dn;
        s_next.stk_wdata = s_reg.cp;
        s_next.cp = s_reg.oper;
        s_next.state = ST_IDLE;
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      // whole struct cleared first so no field leaves reset unknown
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.kind <= K_IRQ;
      s_reg.processor_status_word <= PSW_RST;
      s_reg.sp <= SP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // every output comes straight from the state register
  assign o_prdata = s_reg.prdata;
  assign o_pready = s_reg.pready;
  assign o_pslverr = s_reg.pslverr;
  assign o_irq_ack = s_reg.irq_ack;
  assign o_trap_ack = s_reg.trap_ack;
  assign o_stk_we = s_reg.stk_we;
  assign o_stk_re = s_reg.stk_re;
  assign o_stk_addr = s_reg.stk_addr;
  assign o_stk_wdata = s_reg.stk_wdata;
  assign o_psw = s_reg.processor_status_word;
  assign o_ip = s_reg.ip;
  assign o_csp = s_reg.code_segment_pointer;
  assign o_cp = s_reg.cp;
endmodule : ciesu_top

/* File: ciesu_monitor.sv */
module ciesu_monitor (
  input logic i_clock,
  input logic i_rst,
  input logic i_irq_pet,
  input logic [3:0] i_irq_level,
  input logic [1:0] i_irq_bank,
  input logic o_irq_ack,
  input logic o_trap_ack,
  input logic o_stk_we,
  input logic o_stk_re,
  input logic [15:0] o_stk_addr,
  input logic [15:0] o_psw,
  input logic [15:0] o_cp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  sequence s_two_we;
    o_stk_we ##1 o_stk_we;
  endsequence
  sequence s_two_re;
    o_stk_re ##2 o_stk_re;
  endsequence
  property p_rst;
    $past(i_rst) |-> o_psw == 16'h0000;
  endproperty
  a_rst: assert property (p_rst)
    else $error("status not clear");
  // level before the ack is still the pre-entry one
  property p_acc;
    o_irq_ack |-> i_irq_level > $past(o_psw[15:12]) && $past(o_psw[11]);
  endproperty
  a_acc: assert property (p_acc)
    else $error("request taken wrongly");
  property p_lvl;
    o_irq_ack && !i_irq_pet |-> o_psw[15:12] == i_irq_level && o_psw[9:8] == i_irq_bank;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("entry level or bank");
  property p_pet;
    o_irq_ack && i_irq_pet |-> $stable(o_psw);
  endproperty
  a_pet: assert property (p_pet)
    else $error("event transfer moved status");
  property p_trap;
    o_trap_ack |-> o_psw[15:12] == 4'hF && o_psw[9:8] == 2'h0;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap level or bank");
  property p_cp;
    o_irq_ack || o_trap_ack |-> $stable(o_cp);
  endproperty
  a_cp: assert property (p_cp)
    else $error("context pointer moved");
  property p_push;
    s_two_we |-> o_stk_addr == $past(o_stk_addr) - 16'h0002;
  endproperty
  a_push: assert property (p_push)
    else $error("push step");
  property p_pop;
    s_two_re |-> o_stk_addr == $past(o_stk_addr, 2) + 16'h0002;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop step");
endmodule : ciesu_monitor
bind ciesu_top ciesu_monitor u_mon (.*);

/* File: ciesu_ctrl_model.sv */
module ciesu_ctrl_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_src_en,
  input wire logic i_raise,
  input wire logic i_traise,
  input wire logic i_ack,
  input wire logic i_tack,
  output logic o_req,
  output logic o_treq,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rq;
  logic tq;
  logic [15:0] mem [0:255];
  // dropped in the ack cycle, else the idle engine retakes it
  assign o_req = rq && !i_ack;
  assign o_treq = tq && !i_tack;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rq <= 1'b0;
      tq <= 1'b0;
    end else begin
      rq <= i_src_en && (i_raise || o_req);
      tq <= i_traise || o_treq;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr[8:1]] <= i_wdata;
    end
  end
  // engine captures at the edge ending the strobe cycle; junk outside it
  assign o_rdata = i_re ? mem[i_addr[8:1]] : ~mem[i_addr[8:1]];
endmodule : ciesu_ctrl_model

/* File: cpu_interrupt_entry_status_tb_top.sv */
`define CK(n, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED %s %h %h", n, e, a); end end
module cpu_interrupt_entry_status_tb_top import ciesu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pet = 1'b0;
  logic src_en = 1'b1, raise = 1'b0, traise = 1'b0;
  logic [7:0] paddr = 8'h00, code_segment_pointer;
  logic [31:0] pwdata = 32'h0, rdq, prdata;
  logic pready, pslverr, ack, tack, req, treq, we, re, sq;
  logic [3:0] lvl = 4'h0;
  logic [15:0] sa, swd, srd, processor_status_word, ip, cp;
  int error_cnt = 0, n_compared = 0;
  bit hit;
  ciesu_top dut (
    .i_clock(clk),
    .i_rst(rst),
    .i_psel(psel),
    .i_penable(pen),
    .i_pwrite(pwr),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_irq_req(req),
    .i_irq_pet(pet),
    .i_irq_level(lvl),
    .i_irq_bank(2'h2),
    .i_irq_vec_ip(16'h4000),
    .i_irq_vec_csp(8'h05),
    .o_irq_ack(ack),
    .i_trap_req(treq),
    .i_trap_vec_ip(16'h7000),
    .i_trap_vec_csp(8'h09),
    .o_trap_ack(tack),
    .o_stk_we(we),
    .o_stk_re(re),
    .o_stk_addr(sa),
    .o_stk_wdata(swd),
    .i_stk_rdata(srd),
    .o_psw(processor_status_word),
    .o_ip(ip),
    .o_csp(code_segment_pointer),
    .o_cp(cp)
  );
  ciesu_ctrl_model mdl (
    .i_clock(clk),
    .i_rst(rst),
    .i_src_en(src_en),
    .i_raise(raise),
    .i_traise(traise),
    .i_ack(ack),
    .i_tack(tack),
    .o_req(req),
    .o_treq(treq),
    .i_we(we),
    .i_re(re),
    .i_addr(sa),
    .i_wdata(swd),
    .o_rdata(srd)
  );
  initial begin
    forever #25 clk = ~clk;
  end
  task close_out;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    rdq = prdata;
    sq = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xf
  task automatic idle;
    repeat (16) begin
      xf(0, OFS_STAT, 0);
      if (rdq[0] === 1'b0) return;
    end
    error_cnt++;
    close_out();
  endtask : idle
  // source enable dropped first so a stale request is withdrawn
  task automatic irq(input logic [3:0] l, input logic p);
    @(posedge clk);
    src_en <= 1'b0;
    @(posedge clk);
    src_en <= 1'b1;
    lvl <= l;
    pet <= p;
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
  endtask : irq
  task automatic wt(input bit t, input bit must);
    repeat (16) begin
      @(posedge clk);
      #1;
      hit = t ? tack : ack;
      if (hit) return;
    end
    if (must) begin
      error_cnt++;
      close_out();
    end
  endtask : wt
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    xf(0, OFS_PSW, 0);
    `CK("psw", 32'h0, rdq)
    xf(0, 8'h40, 32'h5);
    `CK("slverr", 1'b1, sq)
    `CK("rd0", 32'h0, rdq)
    xf(1, OFS_PSW, 32'h3800);
    xf(1, OFS_IP, 32'h0100);
    xf(1, OFS_CSP, 32'h03);
    xf(1, OFS_CP, 32'h1111);
    irq(3, 0);
    wt(0, 0);
    `CK("eq", 1'b0, hit)
    irq(5, 0);
    wt(0, 1);
    `CK("psw", 16'h5A00, processor_status_word)
    `CK("ip", 16'h4000, ip)
    `CK("cp", 16'h1111, cp)
    `CK("s0", 16'h3800, mdl.mem[255])
    `CK("s1", 16'h0003, mdl.mem[254])
    `CK("s2", 16'h0100, mdl.mem[253])
    xf(1, OFS_CMD, 32'h1);
    idle();
    `CK("psw", 16'h3800, processor_status_word)
    `CK("csp", 8'h03, code_segment_pointer)
    `CK("ip", 16'h0100, ip)
    irq(5, 1);
    wt(0, 1);
    `CK("pet", 16'h3800, processor_status_word)
    xf(1, OFS_PSW, 32'h3000);
    irq(5, 0);
    wt(0, 0);
    `CK("ien", 1'b0, hit)
    @(posedge clk);
    traise <= 1'b1;
    @(posedge clk);
    traise <= 1'b0;
    wt(1, 1);
    `CK("psw", 16'hF000, processor_status_word)
    `CK("csp", 8'h09, code_segment_pointer)
    xf(1, OFS_CMD, 32'h1);
    idle();
    xf(1, OFS_CFG, 32'h1);
    xf(1, OFS_OPER, 32'h0200);
    xf(1, OFS_CMD, 32'h2);
    idle();
    `CK("psw", 16'h3000, processor_status_word)
    `CK("ip", 16'h0200, ip)
    xf(0, OFS_SP, 0);
    `CK("sp", 32'hFFFC, rdq)
    xf(1, OFS_CMD, 32'h1);
    idle();
    `CK("ip", 16'h0100, ip)
    xf(0, OFS_SP, 0);
    `CK("sp", 32'h0, rdq)
    xf(1, OFS_OPER, 32'h2222);
    xf(1, OFS_CMD, 32'h4);
    idle();
    `CK("cp", 16'h2222, cp)
    `CK("old", 16'h1111, mdl.mem[255])
    close_out();
  end
endmodule : cpu_interrupt_entry_status_tb_top
